/* hw/cpu_vid_config_mux_i2c.sv */
// Behaviour
// - override low and path select low drive all five outputs to zero
// - override high, path low: bank choice 1 picks word A, 0 picks B; that word's route bits pick the source
// - path select high passes the parallel input straight to the outputs
// - outputs driven low only for zero code bits, else released; route set by the three select pins and the stored route bits
// - write protect high blocks serial writes to the stored words
// - slave address is 1001110 with strap 1, 0110111 with strap 0
// - general call and every foreign address are not acknowledged
// - data fall with clock high is start, data rise with clock high is stop
// - device is slave only, never drives clock; master runs 100k or 400k
// - read returns word A, then word B, then the input snapshot
// - master may stop after word A; otherwise the sequence continues
// - serial reads change neither stored word; the start of any transfer recaptures the snapshot
// - snapshot captures the input port on first clock after start
// - snapshot reads zeros in bits 7 to 5, input in bits 4 to 0
// - snapshot is read only; writes never change it
// - write carries one byte: top two bits pick A (00) or B (01)
// - bit 5 and bits 3 to 0 of a stored word form its output code
// - stored route bits: 00 word A, 01 word B, 10 parallel input
// - stored word update takes about 10 ms after the write
module cpu_vid_config_mux_i2c import vid_mux_pkg::*; #(
  parameter int unsigned NV_CYCLES = NV_WRITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic force_zero_n,
  input wire logic path_select,
  input wire logic bank_choice,
  input wire logic write_protect,
  input wire logic address_strap,
  input wire logic [4:0] iport,
  input wire logic [4:0] vid_i,
  output logic [4:0] vid_o,
  output logic [4:0] vid_oe
);

  localparam int TW = $clog2(NV_CYCLES + 1);

  typedef struct packed {
    logic [7:0] word_a;
    logic [7:0] word_b;
    logic [7:0] pend;
    logic dst;
    logic busy;
    logic [TW-1:0] timer;
    logic [4:0] vid_o;
    logic [4:0] vid_oe;
  } core_st_t;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  ctrl_pins_t pins_raw, pins_s;
  logic [7:0] link_raw, link_s;
  logic scl_s, sda_s, strap_s;
  logic [4:0] iport_l;

  assign pins_raw = '{force_zero_n: force_zero_n, path_select: path_select,
                      bank_choice: bank_choice, write_protect: write_protect,
                      iport: iport};
  assign link_raw = {scl_i, sda_i, address_strap, iport};

  vid_sync2 #(.W(9)) u_core_sync (
    .clk(core_clk),
    .rst_b(rst_b),
    .d(pins_raw),
    .q(pins_s)
  );

  vid_sync2 #(.W(8)) u_link_sync (
    .clk(link_clk),
    .rst_b(rst_b),
    .d(link_raw),
    .q(link_s)
  );

  assign {scl_s, sda_s, strap_s, iport_l} = link_s;

  // ************************************************************
  // domain crossings
  // ************************************************************
  link_st_t ln_q, ln_d;
  core_st_t core_q, core_d;
  logic wr_go, wr_evt, commit, upd_evt;

  // write byte stays in ln_q.wr_byte for a full serial byte time
  vid_event_xfer u_wr_xfer (
    .src_clk(link_clk),
    .dst_clk(core_clk),
    .rst_b(rst_b),
    .src_pulse(wr_go),
    .dst_pulse(wr_evt)
  );

  // stored words stay put for the whole update time after a commit
  vid_event_xfer u_upd_xfer (
    .src_clk(core_clk),
    .dst_clk(link_clk),
    .rst_b(rst_b),
    .src_pulse(commit),
    .dst_pulse(upd_evt)
  );

  // ************************************************************
  // serial slave, link clock domain
  // ************************************************************
  logic start_c, stop_c, scl_rise, scl_fall, addr_hit;
  logic [6:0] own_addr;
  logic [1:0] idx_n;
  logic [3:0] cnt_n;
  logic [7:0] sr_n;
  logic [7:0] nxt_byte;

  function automatic logic [7:0] read_byte(input logic [1:0] i, input link_st_t s);
    case (i)
      REG_WORD_A: read_byte = s.word_a;
      REG_WORD_B: read_byte = s.word_b;
      default: read_byte = {SNAP_PAD, s.snap};
    endcase
  endfunction

  assign start_c = scl_s && ln_q.scl_p && ln_q.sda_p && !sda_s;
  assign stop_c = scl_s && ln_q.scl_p && !ln_q.sda_p && sda_s;
  assign scl_rise = scl_s && !ln_q.scl_p;
  assign scl_fall = !scl_s && ln_q.scl_p;
  assign own_addr = strap_s ? SLAVE_ADDR_STRAP_HI : SLAVE_ADDR_STRAP_LO;
  assign addr_hit = (ln_q.sr[7:1] == own_addr) && (ln_q.sr[7:1] != GENERAL_CALL_ADDR);
  assign idx_n = (ln_q.idx == REG_SNAPSHOT) ? REG_WORD_A : ln_q.idx + 2'h1;
  assign cnt_n = ln_q.cnt + 4'h1;
  assign sr_n = {ln_q.sr[6:0], sda_s};
  assign nxt_byte = read_byte(idx_n, ln_q);

  always_comb begin
    ln_d = ln_q;
    wr_go = 1'b0;
    ln_d.scl_p = scl_s;
    ln_d.sda_p = sda_s;
    if (upd_evt) begin
      ln_d.word_a = core_q.word_a;
      ln_d.word_b = core_q.word_b;
    end
    if (start_c) begin
      // a repeated start also lands here and aborts the transfer
      ln_d.state = ST_ADDR;
      ln_d.cnt = 4'h0;
      ln_d.snap_pend = 1'b1;
      ln_d.sda_oe = 1'b0;
    end else if (stop_c) begin
      ln_d.state = ST_IDLE;
      ln_d.snap_pend = 1'b0;
      ln_d.sda_oe = 1'b0;
    end else begin
      if (ln_q.snap_pend && scl_rise) begin
        ln_d.snap = iport_l;
        ln_d.snap_pend = 1'b0;
      end
      case (ln_q.state)
        ST_ADDR: begin
          if (scl_rise) begin
            ln_d.sr = sr_n;
            ln_d.cnt = cnt_n;
          end else if (scl_fall && ln_q.cnt == BITS_PER_BYTE) begin
            ln_d.cnt = 4'h0;
            if (addr_hit) begin
              ln_d.state = ST_ADDR_ACK;
              ln_d.sda_oe = 1'b1;
              ln_d.rw = ln_q.sr[0];
            end else begin
              ln_d.state = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (ln_q.rw) begin
              ln_d.idx = REG_WORD_A;
              ln_d.tx = ln_q.word_a;
              ln_d.sda_oe = !ln_q.word_a[7];
              ln_d.state = ST_RDATA;
            end else begin
              ln_d.sda_oe = 1'b0;
              ln_d.state = ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            ln_d.sr = sr_n;
            ln_d.cnt = cnt_n;
          end else if (scl_fall && ln_q.cnt == BITS_PER_BYTE) begin
            ln_d.cnt = 4'h0;
            ln_d.sda_oe = 1'b1;
            ln_d.wr_byte = ln_q.sr;
            ln_d.state = ST_WACK;
            wr_go = 1'b1;
          end
        end
        ST_WACK: begin
          // only one data byte per write; later bytes go unanswered
          if (scl_fall) begin
            ln_d.sda_oe = 1'b0;
            ln_d.state = ST_IGNORE;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            ln_d.cnt = cnt_n;
            if (cnt_n == BITS_PER_BYTE) begin
              ln_d.sda_oe = 1'b0;
              ln_d.state = ST_RACK;
            end else begin
              ln_d.tx = {ln_q.tx[6:0], 1'b0};
              ln_d.sda_oe = !ln_q.tx[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s) begin
            ln_d.state = ST_IGNORE;
          end else if (scl_fall) begin
            ln_d.idx = idx_n;
            ln_d.tx = nxt_byte;
            ln_d.sda_oe = !nxt_byte[7];
            ln_d.cnt = 4'h0;
            ln_d.state = ST_RDATA;
          end
        end
        ST_IDLE, ST_IGNORE: begin
          ln_d.sda_oe = 1'b0;
        end
        default: begin
          ln_d.state = ST_IDLE;
          ln_d.sda_oe = 1'b0;
        end
      endcase
    end
    ln_d.sda_o = 1'b0;
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      ln_q <= '{state: ST_IDLE, word_a: STORED_WORD_RST,
                word_b: STORED_WORD_RST, default: '0};
    end else begin
      ln_q <= ln_d;
    end
  end

  assign sda_o = ln_q.sda_o;
  assign sda_oe = ln_q.sda_oe;

  // ************************************************************
  // stored words and output mux, core clock domain
  // ************************************************************
  logic [7:0] sel_word, wr_word;
  logic [4:0] stored_code, mux_code;
  logic wr_ok;

  // bit 4 of a stored word always holds zero
  assign wr_word = {ln_q.wr_byte[7:DATA_TOP_POS], 1'b0, ln_q.wr_byte[3:0]};
  assign wr_ok = wr_evt && !pins_s.write_protect && !core_q.busy
                 && (ln_q.wr_byte[ROUTE_HI_POS] == 1'b0);
  assign commit = core_q.busy && (core_q.timer == TW'(1));
  assign sel_word = pins_s.bank_choice ? core_q.word_a : core_q.word_b;

  always_comb begin
    case (sel_word[ROUTE_HI_POS:ROUTE_LO_POS])
      ROUTE_WORD_A: stored_code = word_code(core_q.word_a);
      ROUTE_WORD_B: stored_code = word_code(core_q.word_b);
      default: stored_code = pins_s.iport;
    endcase
  end

  always_comb begin
    if (pins_s.path_select) begin
      mux_code = pins_s.iport;
    end else if (!pins_s.force_zero_n) begin
      mux_code = 5'h00;
    end else begin
      mux_code = stored_code;
    end
  end

  always_comb begin
    core_d = core_q;
    core_d.vid_o = 5'h00;
    core_d.vid_oe = ~mux_code;
    if (wr_ok) begin
      // the slow cell is modelled by holding the new value back
      core_d.busy = 1'b1;
      core_d.pend = wr_word;
      core_d.dst = ln_q.wr_byte[ROUTE_LO_POS];
      core_d.timer = TW'(NV_CYCLES);
    end else if (commit) begin
      core_d.busy = 1'b0;
      core_d.timer = '0;
      if (core_q.dst) begin
        core_d.word_b = core_q.pend;
      end else begin
        core_d.word_a = core_q.pend;
      end
    end else if (core_q.busy) begin
      core_d.timer = core_q.timer - TW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_q <= '{word_a: STORED_WORD_RST, word_b: STORED_WORD_RST,
                  vid_oe: VID_OE_RST, default: '0};
    end else begin
      core_q <= core_d;
    end
  end

  assign vid_o = core_q.vid_o;
  assign vid_oe = core_q.vid_oe;

  // ************************************************************
  // assertions
  // ************************************************************
  a_zero_force: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!pins_s.path_select && !pins_s.force_zero_n) |=> (vid_oe == 5'h1F))
    else $error("outputs not forced low");

  a_path_pass: assert property (@(posedge core_clk) disable iff (!rst_b)
    pins_s.path_select |=> (vid_oe == ~$past(pins_s.iport)))
    else $error("input port not passed through");

  a_bank_word: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!pins_s.path_select && pins_s.force_zero_n && pins_s.bank_choice
     && core_q.word_a[7:6] == ROUTE_WORD_A)
    |=> (vid_oe == ~word_code($past(core_q.word_a))))
    else $error("stored word A not routed");

  a_wp_block: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wr_evt && pins_s.write_protect && !core_q.busy) |=> !core_q.busy)
    else $error("protected write accepted");

  a_word_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
    !commit |=> ($stable(core_q.word_a) && $stable(core_q.word_b)))
    else $error("stored word changed without commit");

  a_nv_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(core_q.busy) |-> core_q.busy [*8])
    else $error("update finished too soon");

  a_start_seen: assert property (@(posedge link_clk) disable iff (!rst_b)
    start_c |=> (ln_q.state == ST_ADDR && !ln_q.sda_oe))
    else $error("start not taken");

  a_addr_ack: assert property (@(posedge link_clk) disable iff (!rst_b)
    (ln_q.state == ST_ADDR && scl_fall && ln_q.cnt == 4'h8 && !start_c && !stop_c)
    |=> (ln_q.sda_oe == $past(addr_hit)))
    else $error("address answer wrong");

  a_snap_ro: assert property (@(posedge link_clk) disable iff (!rst_b)
    !(ln_q.snap_pend && scl_rise && !start_c && !stop_c) |=> $stable(ln_q.snap))
    else $error("snapshot changed outside capture");

  a_read_first: assert property (@(posedge link_clk) disable iff (!rst_b)
    (ln_q.state == ST_ADDR_ACK && ln_q.rw && scl_fall && !start_c && !stop_c)
    |=> (ln_q.tx == $past(ln_q.word_a) && ln_q.idx == REG_WORD_A))
    else $error("read did not begin with word A");

  c_read_ack: cover property (@(posedge link_clk) disable iff (!rst_b)
    ln_q.state == ST_RACK ##1 ln_q.state == ST_RDATA);

  c_write_commit: cover property (@(posedge core_clk) disable iff (!rst_b)
    commit);

  c_force_zero: cover property (@(posedge core_clk) disable iff (!rst_b)
    !pins_s.force_zero_n && !pins_s.path_select);

endmodule // cpu_vid_config_mux_i2c

/* hw/vid_event_xfer.sv */
module vid_event_xfer import vid_mux_pkg::*; (
  input wire logic src_clk,
  input wire logic dst_clk,
  input wire logic rst_b,
  input wire logic src_pulse,
  output logic dst_pulse
);

  // toggle crossing: source flips a level, destination syncs it and
  // looks for a change; pulses must be spaced wider than the sync delay
  logic tgl_q, tgl_d;
  logic [2:0] dst_q, dst_d;

  always_comb begin
    tgl_d = tgl_q ^ src_pulse;
    dst_d = {dst_q[1:0], tgl_q};
  end

  always_ff @(posedge src_clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_q <= 1'b0;
    end else begin
      tgl_q <= tgl_d;
    end
  end

  always_ff @(posedge dst_clk or negedge rst_b) begin
    if (!rst_b) begin
      dst_q <= 3'h0;
    end else begin
      dst_q <= dst_d;
    end
  end

  assign dst_pulse = dst_q[2] ^ dst_q[1];

endmodule // vid_event_xfer

/* hw/vid_mux_pkg.sv */
package vid_mux_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CORE_CLK_HZ = 40_000_000;
  localparam int unsigned NV_WRITE_MS = 10;
  localparam int unsigned NV_WRITE_CYCLES = NV_WRITE_MS * (CORE_CLK_HZ / 1000);

  // ************************************************************
  // addressing and register layout
  // ************************************************************
  localparam logic [6:0] SLAVE_ADDR_STRAP_HI = 7'h4E;
  localparam logic [6:0] SLAVE_ADDR_STRAP_LO = 7'h37;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [1:0] REG_WORD_A = 2'h0;
  localparam logic [1:0] REG_WORD_B = 2'h1;
  localparam logic [1:0] REG_SNAPSHOT = 2'h2;
  localparam int unsigned ROUTE_HI_POS = 7;
  localparam int unsigned ROUTE_LO_POS = 6;
  localparam int unsigned DATA_TOP_POS = 5;
  localparam int unsigned DATA_GAP_POS = 4;
  localparam logic [1:0] ROUTE_WORD_A = 2'h0;
  localparam logic [1:0] ROUTE_WORD_B = 2'h1;
  localparam logic [1:0] ROUTE_IPORT = 2'h2;
  localparam logic [2:0] SNAP_PAD = 3'h0;
  localparam logic [7:0] STORED_WORD_RST = 8'h80;
  localparam logic [4:0] VID_OE_RST = 5'h1F;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ADDR_ACK = 8'h04,
    ST_WDATA = 8'h08,
    ST_WACK = 8'h10,
    ST_RDATA = 8'h20,
    ST_RACK = 8'h40,
    ST_IGNORE = 8'h80
  } link_state_t;

  typedef struct packed {
    logic force_zero_n;
    logic path_select;
    logic bank_choice;
    logic write_protect;
    logic [4:0] iport;
  } ctrl_pins_t;

  typedef struct packed {
    link_state_t state;
    logic scl_p;
    logic sda_p;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic rw;
    logic [1:0] idx;
    logic [7:0] tx;
    logic snap_pend;
    logic [4:0] snap;
    logic [7:0] word_a;
    logic [7:0] word_b;
    logic [7:0] wr_byte;
    logic sda_oe;
    logic sda_o;
  } link_st_t;

  // five-bit code taken from bit 5 and bits 3 to 0 of a stored word
  function automatic logic [4:0] word_code(input logic [7:0] w);
    word_code = {w[DATA_TOP_POS], w[3:0]};
  endfunction

endpackage

/* hw/vid_sync2.sv */
module vid_sync2 import vid_mux_pkg::*; #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_st_t;

  sync_st_t st_q, st_d;

  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule // vid_sync2

/* sim/cpu_vid_config_mux_i2c_tb.sv */
module cpu_vid_config_mux_i2c_tb import vid_mux_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  // short update time keeps the run small; the update waits derive from it
  localparam int unsigned NV = 2000;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b, force_zero_n, path_select, bank_choice, write_protect, address_strap;
  logic [4:0] iport, vid_o, vid_oe, exp5;
  logic scl, sda_pull, sda_o, sda_oe, ack;
  logic [7:0] rd;
  logic [8:0] tbl [4];
  wire logic sda_line;
  wire logic [4:0] vid_line;
  int err_total = 0;
  int samples_checked = 0;

  assign sda_line = sda_pull ? 1'b0 : (sda_oe ? sda_o : 1'b1);
  assign vid_line = ~vid_oe | vid_o;

  always #12.5 core_clk = ~core_clk;
  initial begin
    #7.3;
    forever #62.5 link_clk = ~link_clk;
  end

  cpu_vid_config_mux_i2c #(.NV_CYCLES(NV)) DUT (.core_clk(core_clk), .rst_b(rst_b), .link_clk(link_clk),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .force_zero_n(force_zero_n),
    .path_select(path_select), .bank_choice(bank_choice), .write_protect(write_protect),
    .address_strap(address_strap), .iport(iport), .vid_i(vid_line), .vid_o(vid_o), .vid_oe(vid_oe));

  i2c_host_model host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  // ************************************************************
  // access tasks
  // ************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic tend(input string n);
    $display("test %s done", n);
  endtask

  task automatic chk_mux(input logic [4:0] e);
    tick(6);
    #1;
    chk({3'h0, ~vid_oe}, {3'h0, e});
    chk({3'h0, vid_line}, {3'h0, e});
  endtask

  task automatic wr_reg(input logic [7:0] b);
    host.start();
    host.wr_byte({SLAVE_ADDR_STRAP_HI, 1'b0}, ack);
    chk({7'h00, ack}, 8'h01);
    host.wr_byte(b, ack);
    chk({7'h00, ack}, 8'h01);
    host.stop();
  endtask

  task automatic rd_regs(input logic [7:0] ea, input logic [7:0] eb, input logic [7:0] es);
    host.start();
    host.wr_byte({SLAVE_ADDR_STRAP_HI, 1'b1}, ack);
    chk({7'h00, ack}, 8'h01);
    host.rd_byte(1'b1, rd);
    chk(rd, ea);
    host.rd_byte(1'b1, rd);
    chk(rd, eb);
    host.rd_byte(1'b0, rd);
    chk(rd, es);
    host.stop();
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    rst_b = 1'b0;
    force_zero_n = 1'b1;
    path_select = 1'b0;
    bank_choice = 1'b1;
    write_protect = 1'b0;
    address_strap = 1'b1;
    iport = 5'h0A;
    tbl = '{9'h06F, 9'h09C, 9'h100, 9'h16E};
    tick(3);
    #1;
    chk({3'h0, vid_oe}, 8'h1F);
    chk({7'h00, sda_oe}, 8'h00);
    tick(3);
    rst_b <= 1'b1;
    tick(10);
    chk_mux(5'h0A);
    tend("reset");
    // the old code must stand until the slow update lands
    wr_reg(8'h2B);
    chk_mux(5'h0A);
    tick(NV + 200);
    chk_mux(5'h1B);
    wr_reg(8'h75);
    tick(NV + 200);
    rd_regs(8'h2B, 8'h65, 8'h0A);
    rd_regs(8'h2B, 8'h65, 8'h0A);
    tend("write and read");
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      force_zero_n <= i[2];
      path_select <= i[1];
      bank_choice <= i[0];
      exp5 = i[1] ? 5'h0A : (!i[2] ? 5'h00 : (i[0] ? 5'h1B : 5'h15));
      chk_mux(exp5);
    end
    @(posedge core_clk);
    force_zero_n <= 1'b1;
    path_select <= 1'b0;
    bank_choice <= 1'b1;
    write_protect <= 1'b1;
    tend("mux table");
    wr_reg(8'h11);
    tick(NV + 200);
    chk_mux(5'h1B);
    @(posedge core_clk);
    write_protect <= 1'b0;
    // a destination above word B cannot reach the snapshot
    wr_reg(8'hBF);
    tick(NV + 200);
    @(posedge core_clk);
    iport <= 5'h13;
    rd_regs(8'h2B, 8'h65, 8'h13);
    tend("protect");
    host.start();
    host.wr_byte({SLAVE_ADDR_STRAP_HI, 1'b1}, ack);
    host.rd_byte(1'b0, rd);
    host.stop();
    chk(rd, 8'h2B);
    rd_regs(8'h2B, 8'h65, 8'h13);
    tend("short read");
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      address_strap <= tbl[i][8];
      tick(20);
      host.start();
      host.wr_byte({tbl[i][7:1], 1'b0}, ack);
      host.stop();
      chk({7'h00, ack}, {7'h00, tbl[i][0]});
    end
    tend("addressing");
    give_verdict();
  end
endmodule // cpu_vid_config_mux_i2c_tb

/* sim/i2c_host_model.sv */
module i2c_host_model #(
  parameter int Q = 25
) (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // bus master bit engine
  // ************************************************************
  // scl idles high and stands still between frames; sda is only pulled, the pull-up releases it
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic qtr();
    repeat (Q) @(posedge core_clk);
  endtask

  // data moves only while scl is low; a quarter of 25 core clocks gives 400 kbit framing
  task automatic bit_x(input logic b, output logic r);
    sda_pull <= ~b;
    qtr();
    scl <= 1'b1;
    qtr();
    r = sda_line;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask

  task automatic start();
    sda_pull <= 1'b1;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask

  task automatic stop();
    sda_pull <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_pull <= 1'b0;
    qtr();
    qtr();
  endtask

  // first byte after start is always the address byte, msb first
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  // more high acks the byte so the device carries on
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(~more, r);
  endtask
endmodule // i2c_host_model
